// >>> rtl/pac_cmd_unit.sv
// ASCII command interpreter with serial and USB byte ports.
`default_nettype none
module pac_cmd_unit
  import pac_pkg::*;
#(
  parameter int unsigned TENTH_CYC = pac_pkg::TENTH_CYC,
  parameter int unsigned SETTLE_CYC = pac_pkg::SETTLE_CYC,
  parameter int unsigned HOLD_CYC = pac_pkg::HOLD_CYC,
  parameter int unsigned DISP_CYC = pac_pkg::DISP_CYC,
  parameter logic [8:0] VALVE_TABLE = pac_pkg::VALVE_TABLE_DEF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ser_rx,
  output logic ser_tx,
  input wire pac_pkg::pac_byte_type usb_rx,
  output logic usb_rx_ready,
  output pac_pkg::pac_byte_type usb_tx,
  input wire logic usb_tx_ready,
  input wire pac_pkg::pac_keys_type keys,
  input wire logic adc_valid,
  input wire logic [31:0] adc_sample,
  output pac_pkg::pac_valve_type valves,
  output pac_pkg::pac_mode_type mode,
  output logic lockout,
  output logic baud_fast,
  output logic rate_setting,
  output logic [31:0] disp_voltage
);
  import pac_pkg::*;

  typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_DIV = 3'h1,
    ST_SCALE = 3'h3, ST_SEND = 3'h2, ST_SETTLE = 3'h6} pac_state_type;

  function automatic pac_valve_type pattern(pac_mode_type m);
    case (m)
      MODE_DOWN: pattern = pac_valve_type'(VALVE_TABLE[2:0]);
      MODE_UP: pattern = pac_valve_type'(VALVE_TABLE[5:3]);
      default: pattern = pac_valve_type'(VALVE_TABLE[8:6]);
    endcase
  endfunction

  function automatic logic [63:0] dec_str(logic [9:0] m, logic [3:0] k);
    logic neg;
    logic [3:0] mag;
    neg = k < EXP_BIAS;
    mag = neg ? EXP_BIAS - k : k - EXP_BIAS;
    dec_str = {CH_0 + 8'(m / 10'd100), CH_DOT,
      CH_0 + 8'((m / 10'd10) % 10'd10), CH_0 + 8'(m % 10'd10), CH_E,
      neg ? CH_MINUS : CH_PLUS, CH_0, CH_0 + {4'h0, mag}};
  endfunction

  pac_state_type state;
  logic [1:0] rx_pipe;
  pac_keys_type key_s1, key_s2, key_prev;
  logic rx_s, rx_busy, rx_done, tx_busy, src_usb, cmd_issued, is_dec;
  logic [13:0] baud_div, rx_cnt, tx_cnt;
  logic [3:0] rx_bit, tx_bit, k_reg, rep_len;
  logic [7:0] rx_shift;
  logic [9:0] tx_shift;
  logic [1:0] line_len;
  logic line_ovf;
  logic [7:0] line [0:2];
  logic [71:0] rep;
  logic rate_pend, settle_busy, pend_sub, div_busy, div_done;
  logic [31:0] hold_cnt, settle_cnt, tenth_cnt, disp_cnt, avg, last_sub;
  logic [39:0] sub_sum, snap_sum;
  logic [19:0] sub_cnt, snap_cnt;
  logic [47:0] acc_sum, div_dvd;
  logic [23:0] acc_cnt, div_dvs;
  logic [24:0] div_rem, trial;
  logic [5:0] div_n;
  pac_op_type div_op;

  // Serial receive pin is asynchronous: two stages before use.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_pipe <= 2'h3;
      key_s1 <= 3'h0;
      key_s2 <= 3'h0;
      key_prev <= 3'h0;
    end else begin
      rx_pipe <= {rx_pipe[0], ser_rx};
      key_s1 <= keys;
      key_s2 <= key_s1;
      key_prev <= key_s2;
    end
  end
  assign rx_s = rx_pipe[1];
  assign baud_div = baud_fast ? DIV_FAST : DIV_SLOW;

  // Receiver samples each bit at its middle; a bad stop bit drops the byte.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_busy <= 1'b0;
      rx_cnt <= 14'h0;
      rx_bit <= 4'h0;
      rx_shift <= 8'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        rx_busy <= !rx_s;
        rx_cnt <= {1'b0, baud_div[13:1]};
        rx_bit <= 4'h0;
      end else if (rx_cnt != 14'h0) begin
        rx_cnt <= rx_cnt - 14'h1;
      end else begin
        rx_cnt <= baud_div - 14'h1;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_s) begin
          rx_busy <= 1'b0;
        end else if (rx_bit == UART_LAST_BIT) begin
          rx_busy <= 1'b0;
          rx_done <= rx_s;
        end else if (rx_bit != 4'h0) begin
          rx_shift <= {rx_s, rx_shift[7:1]};
        end
      end
    end
  end

  // Both ports feed one line buffer, so a command may come from either.
  logic in_valid, exec, out_take, set_lock, clr_lock, acc_clr;
  logic mode_go, single_go, key_go, add_en, start_sub, start_cmd;
  logic [7:0] in_data;
  pac_mode_type mode_tgt;
  pac_valve_type single_val;
  logic [31:0] q32;
  logic [3:0] k_now;
  logic [9:0] mant;
  assign usb_rx_ready = state == ST_IDLE && !rx_done;
  assign in_valid = state == ST_IDLE && (rx_done || usb_rx.valid);
  assign in_data = rx_done ? rx_shift : usb_rx.data;
  assign exec = in_valid && in_data == CH_CR && !line_ovf;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_len <= 2'h0;
      line_ovf <= 1'b0;
      line <= '{8'h0, 8'h0, 8'h0};
    end else if (in_valid) begin
      if (in_data == CH_CR) begin
        line_len <= 2'h0;
        line_ovf <= 1'b0;
      end else if (line_len == 2'h3) begin
        line_ovf <= 1'b1;
      end else begin
        line[line_len] <= in_data;
        line_len <= line_len + 2'h1;
      end
    end
  end

  // Only exact upper-case strings match; anything else falls through.
  logic one, is_valve;
  assign one = exec && line_len == 2'h1;
  assign is_valve = exec && line_len == 2'h3 && line[0] == CH_V &&
    line[1] >= CH_1 && line[1] <= CH_3 &&
    (line[2] == CH_N || line[2] == CH_F);
  assign set_lock = one && line[0] == CH_L;
  assign clr_lock = one && line[0] == CH_U;
  always_comb begin
    single_val = valves;
    single_val[2'(line[1] - CH_1)] = line[2] == CH_N;
  end
  assign single_go = is_valve;
  assign key_go = !rate_setting && !lockout && !exec &&
    state == ST_IDLE && |(key_s2 & ~key_prev);
  assign mode_go = (one && (line[0] == CH_M || line[0] == CH_C ||
    line[0] == CH_P)) || key_go;
  always_comb begin
    if (exec) begin
      mode_tgt = line[0] == CH_M ? MODE_DOWN :
        line[0] == CH_C ? MODE_UP : MODE_PURGE;
    end else begin
      mode_tgt = key_s2.up ? MODE_UP :
        key_s2.down ? MODE_DOWN : MODE_PURGE;
    end
  end

  // Purge-side valves settle before the port valve opens to the sample.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      valves <= pac_valve_type'(VALVE_TABLE[8:6]);
      mode <= MODE_PURGE;
      lockout <= 1'b0;
      settle_busy <= 1'b0;
      settle_cnt <= 32'h0;
    end else begin
      if (set_lock) begin
        lockout <= 1'b1;
      end else if (clr_lock) begin
        lockout <= 1'b0;
      end
      if (settle_busy) begin
        settle_cnt <= settle_cnt + 32'h1;
        if (settle_cnt == 32'(SETTLE_CYC - 1)) begin
          settle_busy <= 1'b0;
          valves <= pattern(mode);
        end
      end else if (mode_go) begin
        mode <= mode_tgt;
        if (mode == MODE_PURGE && mode_tgt != MODE_PURGE) begin
          valves <= {pattern(mode_tgt).orifice_bypass_valve,
            pattern(mode_tgt).port_select_valve,
            valves.port_or_purge_valve};
          settle_busy <= 1'b1;
          settle_cnt <= 32'h0;
        end else begin
          valves <= pattern(mode_tgt);
        end
      end else if (single_go) begin
        valves <= single_val;
      end
    end
  end

  // Upstream hold enters rate setting; the chosen rate takes effect on save.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_fast <= 1'b0;
      rate_setting <= 1'b0;
      rate_pend <= 1'b0;
      hold_cnt <= 32'h0;
    end else if (!rate_setting) begin
      hold_cnt <= key_s2.up ? hold_cnt + 32'h1 : 32'h0;
      if (key_s2.up && hold_cnt == 32'(HOLD_CYC - 1)) begin
        rate_setting <= 1'b1;
        rate_pend <= baud_fast;
      end
    end else begin
      hold_cnt <= 32'h0;
      if (key_s2.down && !key_prev.down) begin
        rate_pend <= !rate_pend;
      end
      if (key_s2.purge && !key_prev.purge) begin
        baud_fast <= rate_pend;
        rate_setting <= 1'b0;
      end
    end
  end

  // Tenth-second sub-averages, running sum and count, display refresh.
  assign add_en = div_done && div_op == OP_SUB;
  assign q32 = |div_dvd[47:32] ? 32'hFFFFFFFF : div_dvd[31:0];
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tenth_cnt <= 32'h0;
      sub_sum <= 40'h0;
      sub_cnt <= 20'h0;
      snap_sum <= 40'h0;
      snap_cnt <= 20'h0;
      pend_sub <= 1'b0;
    end else begin
      tenth_cnt <= tenth_cnt + 32'h1;
      if (tenth_cnt == 32'(TENTH_CYC - 1)) begin
        tenth_cnt <= 32'h0;
        snap_sum <= sub_sum;
        snap_cnt <= sub_cnt;
        pend_sub <= sub_cnt != 20'h0;
        sub_sum <= adc_valid ? {8'h0, adc_sample} : 40'h0;
        sub_cnt <= {19'h0, adc_valid};
      end else begin
        if (start_sub) begin
          pend_sub <= 1'b0;
        end
        if (adc_valid) begin
          sub_sum <= sub_sum + {8'h0, adc_sample};
          sub_cnt <= sub_cnt + 20'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_sum <= 48'h0;
      acc_cnt <= 24'h0;
      last_sub <= 32'h0;
      disp_cnt <= 32'h0;
      disp_voltage <= 32'h0;
    end else begin
      // A sub-average that lands with a clear starts the new average.
      if (acc_clr) begin
        acc_sum <= add_en ? {16'h0, q32} : 48'h0;
        acc_cnt <= {23'h0, add_en};
      end else if (add_en) begin
        acc_sum <= acc_sum + {16'h0, q32};
        acc_cnt <= acc_cnt + 24'h1;
      end
      if (add_en) begin
        last_sub <= q32;
      end
      disp_cnt <= disp_cnt + 32'h1;
      if (disp_cnt == 32'(DISP_CYC - 1)) begin
        disp_cnt <= 32'h0;
        disp_voltage <= last_sub;
      end
    end
  end

  // One shared restoring divider; sub-averages take precedence over polls.
  assign start_sub = !div_busy && pend_sub;
  assign start_cmd = !div_busy && !pend_sub && !cmd_issued &&
    (state == ST_DIV || state == ST_SCALE);
  assign trial = {div_rem[23:0], div_dvd[47]};
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_busy <= 1'b0;
      div_done <= 1'b0;
      div_op <= OP_SUB;
      div_dvd <= 48'h0;
      div_dvs <= 24'h0;
      div_rem <= 25'h0;
      div_n <= 6'h0;
    end else begin
      div_done <= 1'b0;
      div_rem <= 25'h0;
      div_n <= 6'h0;
      if (start_sub) begin
        div_busy <= 1'b1;
        div_op <= OP_SUB;
        div_dvd <= {8'h0, snap_sum};
        div_dvs <= {4'h0, snap_cnt};
      end else if (start_cmd && state == ST_DIV) begin
        div_busy <= 1'b1;
        div_op <= OP_AVG;
        div_dvd <= acc_sum;
        div_dvs <= acc_cnt == 24'h0 ? 24'h1 : acc_cnt;
      end else if (start_cmd) begin
        div_busy <= 1'b1;
        div_op <= OP_SCALE;
        div_dvd <= {16'h0, avg};
        div_dvs <= POW10[k_reg - 4'h2][23:0];
      end else if (div_busy) begin
        div_dvd <= {div_dvd[46:0], trial >= {1'b0, div_dvs}};
        div_rem <= trial >= {1'b0, div_dvs} ?
          trial - {1'b0, div_dvs} : trial;
        div_n <= div_n + 6'h1;
        div_busy <= div_n != DIV_STEPS;
        div_done <= div_n == DIV_STEPS;
      end
    end
  end

  always_comb begin
    k_now = 4'h0;
    for (int i = 1; i < 10; i++) begin
      if (q32 >= POW10[i]) begin
        k_now = k_now + 4'h1;
      end
    end
  end
  assign mant = k_now == 4'h0 ? 10'(q32 * 32'd100) : 10'(q32 * 32'd10);

  // Reply shifter, most significant character first.
  assign out_take = state == ST_SEND && (src_usb ? usb_tx_ready : !tx_busy);
  assign usb_tx = '{valid: state == ST_SEND && src_usb, data: rep[71:64]};
  // The status reply keeps the average; readouts and the R command clear it.
  assign acc_clr = (one && line[0] == CH_R) ||
    (out_take && rep_len == 4'h1 && line[0] != CH_S);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      src_usb <= 1'b0;
      cmd_issued <= 1'b0;
      is_dec <= 1'b0;
      rep <= 72'h0;
      rep_len <= 4'h0;
      avg <= 32'h0;
      k_reg <= 4'h0;
    end else begin
      if (start_cmd) begin
        cmd_issued <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          cmd_issued <= 1'b0;
          src_usb <= !rx_done;
          is_dec <= line[0] == CH_K;
          if (one && line[0] == CH_S) begin
            rep <= {CH_V, CH_0 + {5'h0, valves}, CH_LF, 48'h0};
            rep_len <= STAT_LEN;
            state <= ST_SEND;
          end else if (one && (line[0] == CH_D || line[0] == CH_K)) begin
            state <= ST_DIV;
          end else if (mode_go && mode == MODE_PURGE &&
              mode_tgt != MODE_PURGE) begin
            state <= ST_SETTLE;
          end
        end
        ST_DIV: if (div_done && div_op == OP_AVG) begin
          avg <= q32;
          k_reg <= k_now;
          cmd_issued <= 1'b0;
          rep_len <= HEX_LEN;
          state <= ST_SEND;
          if (!is_dec) begin
            for (int i = 0; i < 8; i++) begin
              rep[71 - 8 * i -: 8] <= q32[31 - 4 * i -: 4] > 4'h9 ?
                CH_A + {4'h0, q32[31 - 4 * i -: 4]} :
                CH_0 + {4'h0, q32[31 - 4 * i -: 4]};
            end
            rep[7:0] <= CH_LF;
          end else if (q32 == 32'h0) begin
            rep <= {dec_str(10'h0, EXP_BIAS), CH_LF};
          end else if (k_now < 4'h2) begin
            rep <= {dec_str(mant, k_now), CH_LF};
          end else begin
            state <= ST_SCALE;
          end
        end
        ST_SCALE: if (div_done && div_op == OP_SCALE) begin
          rep <= {dec_str(div_dvd[9:0], k_reg), CH_LF};
          state <= ST_SEND;
        end
        ST_SEND: if (out_take) begin
          rep <= {rep[63:0], 8'h0};
          rep_len <= rep_len - 4'h1;
          if (rep_len == 4'h1) begin
            state <= ST_IDLE;
          end
        end
        ST_SETTLE: if (!settle_busy) begin
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Transmitter: start bit, eight data bits LSB first, one stop bit.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy <= 1'b0;
      tx_cnt <= 14'h0;
      tx_bit <= 4'h0;
      tx_shift <= 10'h3FF;
      ser_tx <= 1'b1;
    end else begin
      ser_tx <= tx_shift[0];
      if (out_take && !src_usb) begin
        tx_busy <= 1'b1;
        tx_shift <= {1'b1, rep[71:64], 1'b0};
        tx_cnt <= baud_div - 14'h1;
        tx_bit <= 4'h0;
      end else if (tx_busy && tx_cnt != 14'h0) begin
        tx_cnt <= tx_cnt - 14'h1;
      end else if (tx_busy) begin
        tx_cnt <= baud_div - 14'h1;
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bit <= tx_bit + 4'h1;
        tx_busy <= tx_bit != UART_LAST_BIT;
      end
    end
  end
endmodule // pac_cmd_unit
`default_nettype wire

// >>> rtl/pac_pkg.sv
// Shared constants and types of the photometer ASCII command unit.
`default_nettype none
package pac_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_SLOW = 1200;
  localparam int BAUD_FAST = 115200;
  localparam logic [13:0] DIV_SLOW = 14'(CLK_HZ / BAUD_SLOW);
  localparam logic [13:0] DIV_FAST =
    14'((CLK_HZ + BAUD_FAST / 2) / BAUD_FAST);
  localparam int TENTH_MS = 100;
  localparam int SETTLE_MS = 500;
  localparam int HOLD_MS = 5000;
  localparam int DISP_MS = 1000;
  localparam int TENTH_CYC = CLK_HZ / 1000 * TENTH_MS;
  localparam int SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
  localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int DISP_CYC = CLK_HZ / 1000 * DISP_MS;
  localparam logic [3:0] UART_LAST_BIT = 4'h9;
  localparam logic [5:0] DIV_STEPS = 6'h2F;
  localparam logic [3:0] EXP_BIAS = 4'h7;
  localparam logic [3:0] HEX_LEN = 4'h9;
  localparam logic [3:0] STAT_LEN = 4'h3;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_3 = 8'h33;
  localparam logic [7:0] CH_A = 8'h37;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_K = 8'h4B;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_L = 8'h4C;
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_P = 8'h50;
  // Valve patterns per mode: [2:0] downstream, [5:3] upstream, [8:6] purge.
  localparam logic [8:0] VALVE_TABLE_DEF = 9'h03D;
  localparam logic [31:0] POW10 [0:9] = '{32'h1, 32'hA, 32'h64,
    32'h3E8, 32'h2710, 32'h186A0, 32'hF4240, 32'h989680,
    32'h5F5E100, 32'h3B9ACA00};
  typedef enum logic [1:0] {MODE_DOWN = 2'h0, MODE_UP = 2'h1,
    MODE_PURGE = 2'h2} pac_mode_type;
  typedef enum logic [1:0] {OP_SUB = 2'h0, OP_AVG = 2'h1,
    OP_SCALE = 2'h2} pac_op_type;
  typedef struct packed {
    logic orifice_bypass_valve;
    logic port_select_valve;
    logic port_or_purge_valve;
  } pac_valve_type;
  typedef struct packed {
    logic up;
    logic down;
    logic purge;
  } pac_keys_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pac_byte_type;
endpackage
`default_nettype wire

// >>> dv/pac_cmd_unit_monitor.sv
// Port checker of the photometer command unit, bound to its top.
`default_nettype none
module pac_cmd_monitor
  import pac_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = 50,
  parameter int unsigned HOLD_CYC = 100,
  parameter logic [8:0] VALVE_TABLE = VALVE_TABLE_DEF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire pac_pkg::pac_byte_type usb_rx,
  input wire pac_pkg::pac_byte_type usb_tx,
  input wire logic usb_tx_ready,
  input wire pac_pkg::pac_keys_type keys,
  input wire pac_pkg::pac_valve_type valves,
  input wire pac_pkg::pac_mode_type mode,
  input wire logic lockout,
  input wire logic baud_fast,
  input wire logic rate_setting
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SET_LO = SETTLE_CYC - 3;
  localparam int SET_HI = SETTLE_CYC + 4;
  localparam int HOLD_LO = HOLD_CYC - 2;
  localparam int HOLD_HI = HOLD_CYC + 6;
  logic [31:0] up_cnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // The raw key is counted, so the key synchroniser adds a few cycles.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt <= '0;
    end else begin
      up_cnt <= keys.up ? up_cnt + 32'h1 : 32'h0;
    end
  end
  a_reset_state: assert property (
    $rose(reset_n) |-> mode == MODE_PURGE && valves == VALVE_TABLE[8:6]
      && !lockout
      && !baud_fast && !rate_setting)
    else $error("state after reset is wrong");
  a_purge_valves: assert property (
    $changed(mode) && mode == MODE_PURGE |-> ##[0:1]
      valves == VALVE_TABLE[8:6])
    else $error("purge valve pattern wrong");
  a_settle_hold: assert property (
    $past(mode) == MODE_PURGE && mode != MODE_PURGE |->
      (valves.port_or_purge_valve == VALVE_TABLE[6])[*8])
    else $error("first valve left purge too early");
  a_settle_end: assert property (
    $past(mode) == MODE_PURGE && mode != MODE_PURGE |->
      ##[SET_LO:SET_HI] valves == VALVE_TABLE[3 * mode +: 3])
    else $error("valves not settled on time");
  a_status_digit: assert property (
    usb_tx.valid && usb_tx_ready && usb_tx.data == CH_V |-> ##[1:2]
      usb_tx.valid && usb_tx.data == CH_0 + 8'(valves))
    else $error("status digit wrong");
  a_reply_upper: assert property (
    usb_tx.valid |-> !(usb_tx.data inside {[8'h61:8'h7A]}))
    else $error("lower case reply byte");
  a_tx_stands: assert property (
    usb_tx.valid && !usb_tx_ready |=> usb_tx.valid && $stable(usb_tx.data))
    else $error("reply byte dropped before taken");
  a_rate_entry: assert property (
    $rose(rate_setting) |-> up_cnt >= HOLD_LO && up_cnt <= HOLD_HI)
    else $error("rate setting entered at wrong hold time");
  a_rate_only: assert property (
    $changed(baud_fast) |-> $past(rate_setting))
    else $error("rate changed outside rate setting");
  a_lock_keys: assert property (
    (lockout && !usb_rx.valid)[*3] |-> $stable(valves))
    else $error("valves moved while locked");
endmodule // pac_cmd_monitor
bind pac_cmd_unit pac_cmd_monitor #(
  .SETTLE_CYC(SETTLE_CYC),
  .HOLD_CYC(HOLD_CYC),
  .VALVE_TABLE(VALVE_TABLE)
) u_mon (
  .ref_clk, .reset_n, .usb_rx, .usb_tx, .usb_tx_ready, .keys, .valves,
  .mode, .lockout, .baud_fast, .rate_setting
);
`default_nettype wire

// >>> dv/pac_host_model.sv
// Host computer model: drives command bytes and collects reply bytes.
`default_nettype none
module pac_host_model
  import pac_pkg::*;
(
  input wire logic ref_clk,
  output pac_pkg::pac_byte_type usb_rx,
  input wire logic usb_rx_ready,
  input wire pac_pkg::pac_byte_type usb_tx,
  output logic usb_tx_ready,
  output logic ser_rx,
  input wire logic ser_tx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] reply [$];
  logic [7:0] sb;
  logic slow = 1'b0;
  logic [2:0] stall = 3'h0;
  int bit_div = DIV_SLOW;
  int stuck = 0;
  initial begin
    usb_rx = '0;
    usb_tx_ready = 1'b1;
    ser_rx = 1'b1;
  end
  // A slow sink is ready one cycle in eight, to exercise reply stalls.
  always @(negedge ref_clk) begin
    stall <= stall + 3'h1;
    usb_tx_ready <= !slow || stall == 3'h0;
  end
  always @(negedge ref_clk) begin
    #1;
    if (usb_tx.valid === 1'b1 && usb_tx_ready === 1'b1) begin
      reply.push_back(usb_tx.data);
    end
  end
  initial forever begin
    @(negedge ser_tx);
    repeat (bit_div + bit_div / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      sb[i] = ser_tx;
      repeat (bit_div) @(posedge ref_clk);
    end
    reply.push_back(sb);
  end
  task automatic send_usb(input logic [7:0] b);
    logic rdy;
    @(negedge ref_clk);
    usb_rx = '{valid: 1'b1, data: b};
    for (int i = 0; i < 400; i++) begin
      rdy = usb_rx_ready;
      @(posedge ref_clk);
      if (rdy) return;
      @(negedge ref_clk);
    end
    stuck++;
  endtask
  // A released byte lane shows the inverse of its last value.
  task automatic usb_idle();
    @(negedge ref_clk);
    usb_rx = '{valid: 1'b0, data: ~usb_rx.data};
  endtask
  task automatic send_ser(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      ser_rx = f[i];
      repeat (bit_div - 1) @(negedge ref_clk);
    end
  endtask
endmodule // pac_host_model
`default_nettype wire

// >>> dv/pac_cmd_unit_bench.sv
// Self-checking bench of the photometer command unit.
`default_nettype none
module pac_cmd_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pac_pkg::*;
  localparam int unsigned SETTLE = 50;
  localparam int unsigned HOLD = 100;
  localparam int unsigned TENTH = 200;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic adc_valid = 1'b0;
  logic [31:0] adc_sample = 32'h0;
  logic [31:0] disp_voltage;
  logic [31:0] lfsr = 32'h3A7BCA65;
  logic [2:0] v;
  pac_keys_type keys = '0;
  pac_byte_type usb_rx, usb_tx;
  pac_valve_type valves;
  pac_mode_type mode;
  logic ser_rx, ser_tx, usb_rx_ready, usb_tx_ready;
  logic lockout, baud_fast, rate_setting;
  int num_errors = 0;
  int checks_done = 0;
  initial forever #50 ref_clk = !ref_clk;
  always @(negedge ref_clk) adc_valid <= !adc_valid;
  pac_cmd_unit #(
    .TENTH_CYC(TENTH), .SETTLE_CYC(SETTLE), .HOLD_CYC(HOLD), .DISP_CYC(300)
  ) dut (
    .ref_clk, .reset_n, .ser_rx, .ser_tx, .usb_rx, .usb_rx_ready, .usb_tx,
    .usb_tx_ready, .keys, .adc_valid, .adc_sample, .valves, .mode,
    .lockout, .baud_fast, .rate_setting, .disp_voltage
  );
  pac_host_model host (
    .ref_clk, .usb_rx, .usb_rx_ready, .usb_tx, .usb_tx_ready, .ser_rx,
    .ser_tx
  );
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic string hex_str(input logic [31:0] x);
    string s;
    s = $sformatf("%h", x);
    return {s.toupper(), "\n"};
  endfunction
  // Mantissa keeps three digits, truncated; readings are 1e-7 V units.
  function automatic string dec_str(input logic [31:0] x);
    longint q;
    int e;
    q = x;
    e = -5;
    while (q >= 1000) begin
      q = q / 10;
      e++;
    end
    while (q < 100) begin
      q = q * 10;
      e--;
    end
    return $sformatf("%0d.%02dE%s%02d\n", q / 100, q % 100,
      e < 0 ? "-" : "+", e < 0 ? -e : e);
  endfunction
  task automatic tally_and_finish();
    num_errors += host.stuck;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_bits(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reply(input string exp);
    logic [79:0] g;
    logic [79:0] e;
    int n;
    g = '0;
    e = '0;
    for (n = 0; n < 6000 && host.reply.size() < exp.len(); n++) begin
      @(negedge ref_clk);
    end
    repeat (20) @(negedge ref_clk);
    foreach (host.reply[i]) g = {g[71:0], host.reply[i]};
    for (int i = 0; i < exp.len(); i++) e = {e[71:0], exp[i]};
    host.reply.delete();
    checks_done++;
    if (g !== e || n == 6000) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cmd(input string s, input bit ser = 1'b0);
    for (int i = 0; i <= s.len(); i++) begin
      if (ser) host.send_ser(i < s.len() ? s[i] : CH_CR);
      else host.send_usb(i < s.len() ? s[i] : CH_CR);
    end
    if (!ser) host.usb_idle();
  endtask
  task automatic press(input logic [2:0] k);
    @(negedge ref_clk);
    keys = k;
    idle(10);
    keys = '0;
    idle(10);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    pac_mode_type mm [4] = '{MODE_DOWN, MODE_PURGE, MODE_UP, MODE_PURGE};
    string ms [4] = '{"M", "P", "C", "P"};
    int k;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    idle(2);
    chk_bits({lockout, baud_fast, rate_setting, mode, valves}, 32'h10);
    $display("test reset done");
    foreach (ms[i]) begin
      cmd(ms[i]);
      idle(SETTLE + 20);
      chk_bits({mode, valves}, {mm[i], VALVE_TABLE_DEF[3 * mm[i] +: 3]});
      chk_reply("");
    end
    $display("test modes done");
    v = 3'h0;
    host.slow = 1'b1;
    repeat (12) begin
      lfsr = next_rand(lfsr);
      k = lfsr % 6;
      v[k % 3] = k < 3;
      cmd($sformatf("V%0d%s", k % 3 + 1, k < 3 ? "N" : "F"));
      idle(3);
      chk_bits(valves, v);
    end
    cmd("s");
    cmd("V1X");
    chk_reply("");
    chk_bits(valves, v);
    cmd("S");
    chk_reply($sformatf("V%0d\n", v));
    $display("test valves done");
    host.slow = 1'b0;
    cmd("P");
    idle(SETTLE + 20);
    cmd("L");
    idle(3);
    chk_bits(lockout, 1);
    press(3'h4);
    press(3'h2);
    chk_bits({mode, valves}, {MODE_PURGE, 3'h0});
    cmd("U");
    idle(3);
    chk_bits(lockout, 0);
    press(3'h2);
    idle(SETTLE + 20);
    chk_bits({mode, valves}, {MODE_DOWN, VALVE_TABLE_DEF[2:0]});
    cmd("P");
    idle(SETTLE + 20);
    $display("test lockout done");
    lfsr = next_rand(lfsr);
    adc_sample = {8'h0, lfsr[23:0] | 24'h1};
    idle(TENTH + 100);
    cmd("R");
    idle(3 * TENTH);
    cmd("D");
    chk_reply(hex_str(adc_sample));
    idle(TENTH + 50);
    cmd("K");
    chk_reply(dec_str(adc_sample));
    chk_bits(disp_voltage, adc_sample);
    $display("test average done");
    keys = 3'h4;
    idle(HOLD + 20);
    keys = '0;
    idle(10);
    chk_bits(rate_setting, 1);
    press(3'h2);
    press(3'h1);
    chk_bits({rate_setting, baud_fast}, 2'b01);
    host.bit_div = DIV_FAST;
    cmd("C");
    idle(SETTLE + 20);
    cmd("S", 1'b1);
    chk_reply($sformatf("V%0d\n", VALVE_TABLE_DEF[5:3]));
    $display("test serial done");
    tally_and_finish();
  end
endmodule // pac_cmd_unit_bench
`default_nettype wire
